//--- cses_consts.svh
`ifndef CSES_CONSTS_SVH
`define CSES_CONSTS_SVH
// address widths
`define CSES_ADDR_W 24
`define CSES_EA1M_W 20
// condition code bit positions
`define CSES_CCR_I 7
`define CSES_CCR_UI 6
// reset value of the user flag enable control
`define CSES_UE_RESET 1'b1
// stack push sequence length in cycles (pc low, pc high, ccr)
`define CSES_PUSH_CYC 3
// vector fetch length in cycles
`define CSES_VEC_CYC 2
`endif

//--- cses_pkg.sv
package cses_pkg;
  // processing states, one-hot
  typedef enum logic [7:0] {
    CSES_RESET = 8'h01,
    CSES_EXEC = 8'h02,
    CSES_STACK = 8'h04,
    CSES_VECTOR = 8'h08,
    CSES_SLEEP = 8'h10,
    CSES_SWSTBY = 8'h20,
    CSES_HWSTBY = 8'h40,
    CSES_BUSREL = 8'h80
  } cses_state_t;
  // exception kinds
  typedef enum logic [1:0] {
    CSES_EXC_NONE = 2'h0,
    CSES_EXC_RESET = 2'h1,
    CSES_EXC_IRQ = 2'h2,
    CSES_EXC_TRAP = 2'h3
  } cses_exc_t;
endpackage

//--- cses_seq_if.sv
`timescale 1ns/100ps
// sequencing handshake between the controller and its step counter
interface cses_seq_if;
  logic start;
  logic [2:0] length;
  logic done;
  modport ctrl (output start, output length, input done);
  modport cnt (input start, input length, output done);
endinterface

//--- cses_step_counter.sv
`timescale 1ns/100ps
// counts the cycles of one exception sub-sequence, pulses done at its end
module cses_step_counter (
  input wire logic mclk,
  input wire logic rst,
  cses_seq_if.cnt seq
);
  logic [2:0] count_r; // remaining cycles
  logic busy_r; // sequence running
  logic done_r; // end pulse

  // load on start; a start while busy restarts the count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= 3'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (seq.start) begin
        count_r <= seq.length;
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (count_r <= 3'h1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          count_r <= count_r - 3'h1;
        end
      end
    end
  end

  assign seq.done = done_r;
endmodule

//--- cses_sequencer.sv
`timescale 1ns/100ps
`include "cses_consts.svh"
module cses_sequencer #(
  parameter int ADDR_W = `CSES_ADDR_W,
  parameter int EA_W = `CSES_EA1M_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chipInitLow, // external init pin, async
  input wire logic hwStandbyIn, // external standby pin, active low, async
  input wire logic wdtOverflow, // watchdog overflow pulse, same clock
  input wire logic irqReq, // pending interrupt, already priority-masked by controller
  input wire logic irqNmi, // pending request is the non-maskable one
  input wire logic instrEnd, // current instruction completes this cycle
  input wire logic instrTrap, // completing instruction is a trap
  input wire logic instrHalt, // completing instruction is the halt
  input wire logic instrNoIrq, // completing instruction is a flag or control-register op
  input wire logic busReqIn, // external bus request
  input wire logic wakeIrq, // wake-up interrupt from sleep or software standby
  input wire logic sleepDepthSelect, // halt goes to software standby when high
  input wire logic userFlagEnable, // aux flag acts as user bit when high
  input wire logic mode1M, // 1-Mbyte address mode
  input wire logic ccrWrEn, // software writes the condition code
  input wire logic [7:0] ccrWrData,
  input wire logic [ADDR_W-1:0] rawAddr, // computed operand or branch address
  input wire logic [ADDR_W-1:0] pcIn, // program counter to stack
  input wire logic [ADDR_W-1:0] stackPtrIn, // stack pointer value
  output cses_pkg::cses_state_t procState,
  output cses_pkg::cses_exc_t excKind,
  output logic [ADDR_W-1:0] effAddr,
  output logic [7:0] condCodeReg,
  output logic pushValid, // a stack write is issued
  output logic [ADDR_W-1:0] pushAddr,
  output logic [ADDR_W-1:0] pushData,
  output logic vecFetch, // vector table read running
  output logic irqAck, // interrupt accepted at a boundary
  output logic cpuClkStop, // cpu and clock halted
  output logic periphReset, // on-chip peripherals held in reset
  output logic busGrant
);
  import cses_pkg::*;

  cses_state_t state_r, state_nxt;
  cses_exc_t exc_r; // exception being handled
  logic [1:0] initSync_r, stbySync_r; // two-stage pin synchronisers
  logic initLvl_r, stbyLvl_r; // synchronised levels for edge checks
  logic [7:0] ccr_r;
  logic irqBlock_r; // suppresses sampling at the next boundary
  logic [ADDR_W-1:0] ea_r, pushAddr_r, pushData_r, sp_r;
  logic pushValid_r, vecFetch_r, irqAck_r, clkStop_r, perRst_r, grant_r;
  logic [1:0] pushIdx_r; // which word is being pushed
  logic seqStartMark;
  cses_seq_if seq ();

  cses_step_counter u_steps (.mclk(mclk), .rst(rst), .seq(seq));

  // address truncation helper, used for both effective and stack addresses
  function automatic logic [ADDR_W-1:0] trunc_addr(input logic [ADDR_W-1:0] a,
                                                  input logic m);
    trunc_addr = m ? {{(ADDR_W-EA_W){1'b0}}, a[EA_W-1:0]} : a;
  endfunction

  // pins cross into mclk through two flops before any use
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      initSync_r <= 2'h0;
      stbySync_r <= 2'h3;
      initLvl_r <= 1'b0;
      stbyLvl_r <= 1'b1;
    end else begin
      initSync_r <= {initSync_r[0], chipInitLow};
      stbySync_r <= {stbySync_r[0], hwStandbyIn};
      initLvl_r <= initSync_r[1];
      stbyLvl_r <= stbySync_r[1];
    end
  end

  wire initLow = ~initSync_r[1];
  wire initRise = initSync_r[1] & ~initLvl_r;
  wire stbyLow = ~stbySync_r[1];
  // the mask bit only gates maskable requests, nmi passes it
  // a flag or control-register op closes its own boundary to interrupts, so the
  // mask value that the op writes is in force before anything is sampled again
  // limitation: a request that arrives then simply waits for the next boundary
  // irqBlock_r covers the reset sequence and the first boundary after it
  wire irqTake = irqReq & (irqNmi | ~ccr_r[`CSES_CCR_I]) & ~irqBlock_r & ~instrNoIrq;
  wire atBoundary = (state_r == CSES_EXEC) & instrEnd;

  // next processing state
  // the case picks the normal successor; the pin and watchdog overrides below
  // are applied last so that they beat anything the case has chosen
  // a sequence start is cancelled by an override, since the counter must not
  // keep running into a state that no longer waits for it
  always_comb begin
    state_nxt = state_r;
    seqStartMark = 1'b0;
    case (state_r)
      CSES_RESET: begin
        if (initRise) begin
          state_nxt = CSES_VECTOR;
          seqStartMark = 1'b1;
        end
      end
      CSES_EXEC: begin
        if (busReqIn) begin
          state_nxt = CSES_BUSREL;
        end else if (atBoundary & irqTake) begin
          state_nxt = CSES_STACK;
          seqStartMark = 1'b1;
        end else if (atBoundary & instrTrap) begin
          state_nxt = CSES_STACK;
          seqStartMark = 1'b1;
        end else if (atBoundary & instrHalt) begin
          state_nxt = sleepDepthSelect ? CSES_SWSTBY : CSES_SLEEP;
        end
      end
      CSES_STACK: begin
        if (seq.done) begin
          state_nxt = CSES_VECTOR;
          seqStartMark = 1'b1;
        end
      end
      CSES_VECTOR: begin
        if (seq.done) begin
          state_nxt = CSES_EXEC;
        end
      end
      CSES_SLEEP, CSES_SWSTBY: begin
        if (wakeIrq) begin
          state_nxt = CSES_EXEC;
        end
      end
      CSES_HWSTBY: begin
        // leaving hardware standby goes through reset
        if (!stbyLow) begin
          state_nxt = CSES_RESET;
        end
      end
      CSES_BUSREL: begin
        if (!busReqIn) begin
          state_nxt = CSES_EXEC;
        end
      end
      default: state_nxt = CSES_RESET;
    endcase
    // overrides in priority: standby pin, then reset sources
    if (stbyLow) begin
      state_nxt = CSES_HWSTBY;
      seqStartMark = 1'b0;
    end else if (initLow | wdtOverflow) begin
      state_nxt = CSES_RESET;
      seqStartMark = 1'b0;
    end
  end

  // the counter length follows the state being entered: three words to push,
  // or the vector read; the counter holds done one cycle past its last step,
  // so each sub-sequence lasts its length plus one cycle
  assign seq.start = seqStartMark;
  assign seq.length = (state_nxt == CSES_STACK) ? 3'(`CSES_PUSH_CYC) : 3'(`CSES_VEC_CYC);

  // state register and current exception kind
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= CSES_RESET;
      exc_r <= CSES_EXC_RESET;
    end else begin
      state_r <= state_nxt;
      if (state_nxt == CSES_RESET) begin
        exc_r <= CSES_EXC_RESET;
      end else if (state_r == CSES_EXEC && state_nxt == CSES_STACK) begin
        exc_r <= (atBoundary & irqTake) ? CSES_EXC_IRQ : CSES_EXC_TRAP;
      end else if (state_r == CSES_VECTOR && state_nxt == CSES_EXEC) begin
        exc_r <= CSES_EXC_NONE;
      end
    end
  end

  // interrupt blocking during reset handling and at the first boundary after it
  // set throughout the reset state and the reset vector fetch; the first
  // instruction boundary that follows clears it, whatever that instruction was
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqBlock_r <= 1'b1;
    end else if (state_r == CSES_RESET || (state_r == CSES_VECTOR && exc_r == CSES_EXC_RESET)) begin
      irqBlock_r <= 1'b1;
    end else if (atBoundary) begin
      // flag ops are refused at their own boundary through irqTake
      irqBlock_r <= 1'b0;
    end
  end

  // condition code register; hardware mask setting wins over a software write
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ccr_r <= 8'h80;
    end else if (state_nxt == CSES_RESET) begin
      // set on the very edge that enters reset, so the mask is up while in it
      ccr_r[`CSES_CCR_I] <= 1'b1;
    end else if (state_r == CSES_STACK && seq.done) begin
      ccr_r[`CSES_CCR_I] <= 1'b1;
      // with user flags enabled the aux flag is left alone
      if (!userFlagEnable) begin
        ccr_r[`CSES_CCR_UI] <= 1'b1;
      end
    end else if (ccrWrEn && state_r == CSES_EXEC) begin
      ccr_r <= ccrWrData;
    end
  end

  // stack pushes: pc low word, pc high part, then flags, each at a lower address
  // the stack pointer is captured at entry so a change on its input during the
  // pushes cannot split the frame across two different bases
  // the flags word is the value before the mask update, which comes at done
  // in 1-Mbyte mode the push address is truncated like any other address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pushValid_r <= 1'b0;
      pushIdx_r <= 2'h0;
      sp_r <= '0;
      pushAddr_r <= '0;
      pushData_r <= '0;
    end else if (state_r == CSES_EXEC && state_nxt == CSES_STACK) begin
      sp_r <= stackPtrIn;
      pushIdx_r <= 2'h0;
      pushValid_r <= 1'b0;
    end else if (state_r == CSES_STACK && !seq.done) begin
      pushValid_r <= 1'b1;
      pushIdx_r <= pushIdx_r + 2'h1;
      pushAddr_r <= trunc_addr(sp_r - ADDR_W'({pushIdx_r, 1'b0}) - ADDR_W'(2), mode1M);
      if (pushIdx_r == 2'h0) begin
        pushData_r <= {{(ADDR_W-16){1'b0}}, pcIn[15:0]};
      end else if (pushIdx_r == 2'h1) begin
        pushData_r <= {16'h0, pcIn[ADDR_W-1:16]};
      end else begin
        pushData_r <= {{(ADDR_W-8){1'b0}}, ccr_r};
      end
    end else begin
      pushValid_r <= 1'b0;
    end
  end

  // effective address, acknowledge, vector fetch, power and bus outputs
  // all of these follow state_nxt so that they line up with procState
  // rather than trailing it by a cycle; effAddr is one cycle behind rawAddr
  // peripheral reset is also held in the reset state itself, which keeps
  // peripherals quiet until the reset vector fetch starts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ea_r <= '0;
      vecFetch_r <= 1'b0;
      irqAck_r <= 1'b0;
      clkStop_r <= 1'b0;
      perRst_r <= 1'b1;
      grant_r <= 1'b0;
    end else begin
      ea_r <= trunc_addr(rawAddr, mode1M);
      vecFetch_r <= (state_nxt == CSES_VECTOR);
      irqAck_r <= (state_r == CSES_EXEC) && (state_nxt == CSES_STACK) && atBoundary && irqTake;
      // sleep keeps the clock for peripherals; standby stops it
      clkStop_r <= (state_nxt == CSES_SLEEP) || (state_nxt == CSES_SWSTBY) ||
                   (state_nxt == CSES_HWSTBY);
      perRst_r <= (state_nxt == CSES_SWSTBY) || (state_nxt == CSES_HWSTBY) ||
                  (state_nxt == CSES_RESET);
      grant_r <= (state_nxt == CSES_BUSREL);
    end
  end

  // every output is a plain copy of a register
  assign procState = state_r;
  assign excKind = exc_r;
  assign effAddr = ea_r;
  assign condCodeReg = ccr_r;
  assign pushValid = pushValid_r;
  assign pushAddr = pushAddr_r;
  assign pushData = pushData_r;
  assign vecFetch = vecFetch_r;
  assign irqAck = irqAck_r;
  assign cpuClkStop = clkStop_r;
  assign periphReset = perRst_r;
  assign busGrant = grant_r;
endmodule

//--- cses_props_properties.sv
`timescale 1ns/100ps
// port-level checks of the sequencer
module cses_props #(
  parameter int ADDR_W = 24
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic chipInitLow,
  input wire logic hwStandbyIn,
  input wire logic wdtOverflow,
  input wire logic irqReq,
  input wire logic busReqIn,
  input wire logic instrEnd,
  input wire logic instrTrap,
  input wire logic instrHalt,
  input wire logic instrNoIrq,
  input wire logic sleepDepthSelect,
  input wire logic userFlagEnable,
  input wire logic mode1M,
  input wire logic [ADDR_W-1:0] rawAddr,
  input wire cses_pkg::cses_state_t procState,
  input wire logic [ADDR_W-1:0] effAddr,
  input wire logic [7:0] condCodeReg,
  input wire logic pushValid,
  input wire logic vecFetch,
  input wire logic irqAck,
  input wire logic cpuClkStop,
  input wire logic periphReset
);
  import cses_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // boundary with nothing of higher rank pending, so trap or halt must win
  logic quiet;
  assign quiet = procState == CSES_EXEC && instrEnd && !irqReq && !wdtOverflow
    && chipInitLow && hwStandbyIn && !busReqIn;
  // three stack writes, then three vector cycles with the mask already set
  // (the step counter holds one extra cycle past its length)
  sequence s_push;
    pushValid [*3];
  endsequence
  sequence s_vec;
    (vecFetch && condCodeReg[7]) [*3];
  endsequence
  // a reset source or the standby pin may cut the entry short on purpose
  property p_entry;
    disable iff (rst || !chipInitLow || !hwStandbyIn || wdtOverflow)
    irqAck |=> s_push ##1 s_vec ##1 procState == CSES_EXEC;
  endproperty
  a_entry: assert property (p_entry) else $error("bad entry walk");
  property p_ackst;
    irqAck |-> procState == CSES_STACK;
  endproperty
  a_ackst: assert property (p_ackst) else $error("ack outside stacking");
  property p_noirq;
    procState == CSES_EXEC && instrEnd && instrNoIrq |=> !irqAck;
  endproperty
  a_noirq: assert property (p_noirq) else $error("irq after flag op");
  property p_trap;
    quiet && instrTrap |=> procState == CSES_STACK;
  endproperty
  a_trap: assert property (p_trap) else $error("trap not taken");
  property p_halt;
    quiet && instrHalt && !instrTrap |=> procState == (sleepDepthSelect ? CSES_SWSTBY : CSES_SLEEP);
  endproperty
  a_halt: assert property (p_halt) else $error("bad halt state");
  property p_mask;
    $rose(vecFetch) && $past(pushValid) && !userFlagEnable |-> condCodeReg[7:6] == 2'b11;
  endproperty
  a_mask: assert property (p_mask) else $error("aux mask not set");
  property p_init;
    (!chipInitLow && hwStandbyIn) [*3] |=> procState == CSES_RESET && condCodeReg[7];
  endproperty
  a_init: assert property (p_init) else $error("init pin ignored");
  property p_wdt;
    wdtOverflow && hwStandbyIn && chipInitLow |-> ##[1:3] procState == CSES_RESET;
  endproperty
  a_wdt: assert property (p_wdt) else $error("overflow ignored");
  property p_hw_standby_in;
    !hwStandbyIn [*3] |-> ##2 procState == CSES_HWSTBY && cpuClkStop && periphReset;
  endproperty
  a_hw_standby_in: assert property (p_hw_standby_in) else $error("standby pin ignored");
  property p_ea;
    mode1M |=> effAddr == ADDR_W'($past(rawAddr[19:0]));
  endproperty
  a_ea: assert property (p_ea) else $error("address not truncated");
endmodule
bind cses_sequencer cses_props #(.ADDR_W(ADDR_W)) cses_props_i (.mclk, .rst, .chipInitLow,
  .hwStandbyIn, .wdtOverflow, .irqReq, .busReqIn, .instrEnd, .instrTrap, .instrHalt, .instrNoIrq,
  .sleepDepthSelect, .userFlagEnable, .mode1M, .rawAddr, .procState, .effAddr, .condCodeReg,
  .pushValid, .vecFetch, .irqAck, .cpuClkStop, .periphReset);

//--- cses_irq_model.sv
`timescale 1ns/100ps
// interrupt controller stand-in
module cses_irq_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic raise, // bench asks for a request
  input wire logic nmi, // request is the non-maskable one
  input wire logic irqAck,
  output logic irqReq,
  output logic irqNmi
);
  // pending until acknowledged, so a refused request waits for a later boundary
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irqReq <= 1'b0;
      irqNmi <= 1'b0;
    end else if (irqAck) begin
      irqReq <= 1'b0;
    end else if (raise) begin
      irqReq <= 1'b1;
      irqNmi <= nmi;
    end
  end
endmodule

//--- cses_sequencer_test.sv
`timescale 1ns/100ps
module cses_sequencer_test;
  import cses_pkg::*;
  // driven at falling edges; init pin starts low so the chip waits in reset
  logic mclk = 1'b0, rst = 1'b1, chipInitLow = 1'b0, hwStandbyIn = 1'b1, wdtOverflow = 1'b0;
  logic instrEnd = 1'b0, instrTrap = 1'b0, instrHalt = 1'b0, instrNoIrq = 1'b0, wakeIrq = 1'b0;
  logic sleepDepthSelect = 1'b0, userFlagEnable = 1'b1, mode1M = 1'b0, raise = 1'b0, nmi = 1'b0;
  // tied: no software flag writes here; the bus request is raised once for the release check
  logic busReqIn = 1'b0, ccrWrEn = 1'b0;
  logic [7:0] ccrWrData = 8'h00, cc, condCodeReg;
  logic [23:0] rawAddr = 24'h000000, pcIn = 24'h000000, stackPtrIn = 24'h000000;
  logic [23:0] effAddr, pushAddr, pushData;
  logic irqReq, irqNmi, pushValid, vecFetch, irqAck, cpuClkStop, periphReset, busGrant;
  cses_state_t procState;
  cses_exc_t excKind;
  int fails = 0, tests_run = 0, r;
  cses_sequencer cses_sequencer_i (.mclk, .rst, .chipInitLow, .hwStandbyIn, .wdtOverflow, .irqReq,
    .irqNmi, .instrEnd, .instrTrap, .instrHalt, .instrNoIrq, .busReqIn, .wakeIrq, .sleepDepthSelect,
    .userFlagEnable, .mode1M, .ccrWrEn, .ccrWrData, .rawAddr, .pcIn, .stackPtrIn, .procState,
    .excKind, .effAddr, .condCodeReg, .pushValid, .pushAddr, .pushData, .vecFetch, .irqAck,
    .cpuClkStop, .periphReset, .busGrant);
  cses_irq_model cses_irq_model_i (.mclk, .rst, .raise, .nmi, .irqAck, .irqReq, .irqNmi);
  always #5 mclk = ~mclk;
  // expected words: pc low, pc high, then the flags before entry
  function automatic logic [23:0] pushExp(int i, logic [7:0] f);
    return i == 0 ? {8'h00, pcIn[15:0]} : i == 1 ? {16'h0000, pcIn[23:16]} : {16'h0000, f};
  endfunction
  function automatic logic [23:0] eaExp(logic m, logic [23:0] a);
    return m ? {4'h0, a[19:0]} : a;
  endfunction
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // bounded wait, then the state itself is compared
  task automatic waitState(input cses_state_t s);
    for (int n = 0; n < 40 && procState !== s; n++) @(negedge mclk);
    chk(procState, s);
  endtask
  task automatic boot();
    chipInitLow = 1'b0;
    cyc(4);
    chipInitLow = 1'b1;
    waitState(CSES_EXEC);
  endtask
  // one-cycle instruction-end pulse; returns in the cycle after the boundary
  task automatic bound(input logic t, input logic h, input logic n);
    @(negedge mclk);
    {instrEnd, instrTrap, instrHalt, instrNoIrq} = {1'b1, t, h, n};
    @(negedge mclk);
    {instrEnd, instrTrap, instrHalt, instrNoIrq} = 4'h0;
  endtask
  task automatic req();
    raise = 1'b1;
    nmi = 1'b1;
    cyc(1);
    raise = 1'b0;
  endtask
  // alternate the flag enable so both masking modes are seen
  task automatic rnd();
    userFlagEnable = ~userFlagEnable;
    pcIn = 24'($urandom);
    stackPtrIn = 24'($urandom);
    cc = condCodeReg;
  endtask
  task automatic entry(input logic [7:0] f, input cses_exc_t k);
    for (int i = 0; i < 3; i++) begin
      @(negedge mclk);
      chk({pushValid, excKind}, {1'b1, k});
      chk(pushAddr, stackPtrIn - 24'(2 * i + 2));
      chk(pushData, pushExp(i, f));
    end
    cyc(1);
    chk(vecFetch, 1'b1);
    waitState(CSES_EXEC);
    chk(condCodeReg, {1'b1, ~userFlagEnable | f[6], f[5:0]});
  endtask
  initial begin
    void'($urandom(32'h9a0b));
    cyc(6);
    rst = 1'b0;
    boot();
    chk(condCodeReg[7], 1'b1);
    req();
    bound(1'b0, 1'b0, 1'b0);
    chk(irqAck, 1'b0);
    for (r = 0; r < 3; r++) begin
      req();
      rnd();
      bound(r == 1, 1'b0, r == 2);
      if (r == 2) chk(irqAck, 1'b0);
      if (r == 2) bound(1'b0, 1'b0, 1'b0);
      chk(irqAck, 1'b1);
      entry(cc, CSES_EXC_IRQ);
    end
    rnd();
    bound(1'b1, 1'b0, 1'b0);
    chk(procState, CSES_STACK);
    entry(cc, CSES_EXC_TRAP);
    for (r = 0; r < 8; r++) begin
      mode1M = 1'($urandom);
      rawAddr = r == 0 ? 24'hffffff : 24'($urandom);
      cyc(1);
      chk(effAddr, eaExp(mode1M, rawAddr));
    end
    mode1M = 1'b0;
    req();
    bound(1'b0, 1'b0, 1'b0);
    chipInitLow = 1'b0;
    waitState(CSES_RESET);
    boot();
    for (r = 0; r < 2; r++) begin
      sleepDepthSelect = r[0];
      bound(1'b0, 1'b1, 1'b0);
      chk(procState, r ? CSES_SWSTBY : CSES_SLEEP);
      cyc(1);
      chk(periphReset, r[0]);
      wakeIrq = 1'b1;
      waitState(CSES_EXEC);
      wakeIrq = 1'b0;
    end
    busReqIn = 1'b1;
    cyc(2);
    chk({procState == CSES_BUSREL, busGrant}, 2'b11);
    busReqIn = 1'b0;
    waitState(CSES_EXEC);
    wdtOverflow = 1'b1;
    cyc(1);
    wdtOverflow = 1'b0;
    waitState(CSES_RESET);
    boot();
    bound(1'b0, 1'b1, 1'b0);
    hwStandbyIn = 1'b0;
    waitState(CSES_HWSTBY);
    cyc(1);
    chk({cpuClkStop, periphReset}, 2'b11);
    hwStandbyIn = 1'b1;
    waitState(CSES_RESET);
    results();
  end
  // the sequence needs well under 2000 cycles; this only cuts a hang short
  initial begin
    #50us;
    fails++;
    results();
  end
endmodule
